/* hdl/flash_cmd_host.v */
`timescale 1ns/100ps
`include "flash_host_consts.vh"
module flash_cmd_host #(
	parameter AW = 23,                          // Flash address width
	parameter DW = 16                           // Flash data width
) (
	input  wire          mclk,                  // System clock
	input  wire          sys_rst,               // Synchronous reset, high
	input  wire          op_valid,              // Operation request
	input  wire [3:0]    op_code,               // Requested operation
	input  wire [AW-1:0] op_addr,               // Target address
	input  wire [DW-1:0] op_data,               // Program word
	output reg           op_ready,              // Ready for a request
	output reg           op_done,               // Operation finished pulse
	output reg           op_rejected,           // Refused request pulse
	output reg  [DW-1:0] rd_data,               // Captured read word
	output reg  [7:0]    status_bits,           // Last status readout
	output reg           erase_suspended,       // Tracked erase suspend
	output reg           program_suspended,     // Tracked program suspend
	output reg           need_clear,            // Clear status owed
	output reg  [AW-1:0] flash_addr,            // Flash address pins
	output reg  [DW-1:0] flash_dq_out,          // Data driven to flash
	output reg           flash_dq_oe,           // Data drive enable
	input  wire [DW-1:0] flash_dq_in,           // Data from flash
	output reg           flash_ce_n,            // Chip enable, low
	output reg           flash_oe_n,            // Output enable, low
	output reg           flash_we_n,            // Write enable, low
	output reg           reset_power_down_n     // Device reset, low
);

	localparam [2:0] S_IDLE = 3'd0;             // Waiting for request
	localparam [2:0] S_WR   = 3'd1;             // Write strobe low
	localparam [2:0] S_WREC = 3'd2;             // Write recovery
	localparam [2:0] S_RD   = 3'd3;             // Read strobe low
	localparam [2:0] S_RREC = 3'd4;             // Read recovery
	localparam [2:0] S_END  = 3'd5;             // Report completion

	reg [2:0]    state;                         // Bus sequencer state
	reg [2:0]    cnt;                           // Strobe timer
	reg          second;                        // Second write pending
	reg [7:0]    cmd2;                          // Second cycle byte
	reg          cmd2_data;                     // Second cycle uses op_data
	reg          is_read;                       // Current op is a read
	reg          is_status;                     // Read targets status
	reg [3:0]    cur_op;                        // Operation in flight
	reg [7:0]    first_cmd;                     // First cycle byte
	reg          has_second;                    // Op has two writes
	reg          allowed;                       // Op legal in this mode
	reg          erase_active;                  // Erase issued, not done
	reg          prog_active;                   // Program issued, not done
	reg [DW-1:0] op_data_hold;                  // Program word held

	// Encode first cycle and whether a second follows
	always @* begin
		first_cmd  = `CMD_READ_ARRAY;
		has_second = 1'b0;
		case (op_code)
			`OP_READ_IDENT:   first_cmd = `CMD_READ_IDENT;
			`OP_READ_QUERY:   first_cmd = `CMD_READ_QUERY;
			`OP_READ_STATUS:  first_cmd = `CMD_READ_STATUS;
			`OP_CLEAR_STATUS: first_cmd = `CMD_CLEAR_STATUS;
			`OP_PROGRAM: begin
				first_cmd  = `CMD_PROGRAM_SETUP;
				has_second = 1'b1;
			end
			`OP_ERASE: begin
				first_cmd  = `CMD_ERASE_SETUP;
				has_second = 1'b1;
			end
			`OP_SUSPEND:      first_cmd = `CMD_SUSPEND;
			`OP_RESUME:       first_cmd = `CMD_CONFIRM;
			`OP_LOCK, `OP_UNLOCK, `OP_LOCK_DOWN: begin
				first_cmd  = `CMD_PROTECT_SETUP;
				has_second = 1'b1;
			end
			`OP_PROT_PROGRAM: begin
				first_cmd  = `CMD_PROT_PROGRAM;
				has_second = 1'b1;
			end
			default:          first_cmd = `CMD_READ_ARRAY;
		endcase
	end

	// Legal command filter per suspend mode
	always @* begin
		allowed = 1'b1;
		if (op_code > `OP_READ) begin
			allowed = 1'b0;
		end else if (program_suspended) begin
			case (op_code)
				`OP_READ_ARRAY, `OP_READ_STATUS, `OP_READ_IDENT, `OP_READ_QUERY,
				`OP_RESUME, `OP_READ: allowed = 1'b1;
				default:              allowed = 1'b0;
			endcase
		end else if (erase_active || prog_active) begin
			case (op_code)
				`OP_READ_STATUS, `OP_SUSPEND, `OP_READ: allowed = 1'b1;
				default:                                allowed = 1'b0;
			endcase
		end else if (erase_suspended) begin
			case (op_code)
				`OP_CLEAR_STATUS, `OP_ERASE, `OP_SUSPEND, `OP_PROT_PROGRAM:
					allowed = 1'b0;
				default: allowed = 1'b1;
			endcase
		end else if (need_clear && (op_code == `OP_PROGRAM || op_code == `OP_ERASE)) begin
			allowed = 1'b0;
		end
	end

	// Bus sequencer and suspend tracking
	always @(posedge mclk) begin
		if (sys_rst) begin
			state              <= S_IDLE;
			cnt                <= 3'd0;
			second             <= 1'b0;
			cmd2               <= 8'h00;
			cmd2_data          <= 1'b0;
			is_read            <= 1'b0;
			is_status          <= 1'b0;
			cur_op             <= 4'h0;
			erase_active       <= 1'b0;
			prog_active        <= 1'b0;
			op_ready           <= 1'b0;
			op_done            <= 1'b0;
			op_rejected        <= 1'b0;
			rd_data            <= {DW{1'b0}};
			status_bits        <= 8'h00;
			erase_suspended    <= 1'b0;
			program_suspended  <= 1'b0;
			need_clear         <= 1'b0;
			flash_addr         <= {AW{1'b0}};
			flash_dq_out       <= {DW{1'b0}};
			flash_dq_oe        <= 1'b0;
			flash_ce_n         <= 1'b1;
			flash_oe_n         <= 1'b1;
			flash_we_n         <= 1'b1;
			reset_power_down_n <= 1'b1;
		end else begin
			op_done     <= 1'b0;
			op_rejected <= 1'b0;
			case (state)
				// Accept or refuse a request
				S_IDLE: begin
					op_ready <= 1'b1;
					if (op_valid && op_ready) begin
						op_ready <= 1'b0;
						cur_op   <= op_code;
						if (!allowed) begin
							op_rejected <= 1'b1;
							state       <= S_END;
						end else if (op_code == `OP_READ) begin
							is_read    <= 1'b1;
							flash_addr <= op_addr;
							flash_ce_n <= 1'b0;
							flash_oe_n <= 1'b0;
							cnt        <= 3'd0;
							state      <= S_RD;
						end else begin
							is_read      <= 1'b0;
							second       <= has_second;
							cmd2_data    <= (op_code == `OP_PROGRAM) ||
							                (op_code == `OP_PROT_PROGRAM);
							cmd2         <= (op_code == `OP_LOCK) ? `CMD_LOCK :
							                (op_code == `OP_LOCK_DOWN) ? `CMD_LOCK_DOWN :
							                `CMD_CONFIRM;
							flash_addr   <= op_addr;
							flash_dq_out <= {{(DW-8){1'b0}}, first_cmd};
							flash_dq_oe  <= 1'b1;
							flash_ce_n   <= 1'b0;
							flash_we_n   <= 1'b0;
							cnt          <= 3'd0;
							state        <= S_WR;
						end
					end
				end
				// Hold write strobe low
				S_WR: begin
					cnt <= cnt + 3'd1;
					if (cnt == `T_STROBE_CYC - 1) begin
						flash_we_n <= 1'b1;
						flash_ce_n <= 1'b1;
						cnt        <= 3'd0;
						state      <= S_WREC;
					end
				end
				// Release then maybe second write
				S_WREC: begin
					cnt <= cnt + 3'd1;
					if (cnt == `T_RECOVER_CYC - 1) begin
						cnt <= 3'd0;
						if (second) begin
							second       <= 1'b0;
							flash_dq_out <= cmd2_data ? op_data_hold : {{(DW-8){1'b0}}, cmd2};
							flash_ce_n   <= 1'b0;
							flash_we_n   <= 1'b0;
							state        <= S_WR;
						end else begin
							flash_dq_oe <= 1'b0;
							state       <= S_END;
							// Track device mode after writes
							case (cur_op)
								`OP_READ_STATUS, `OP_PROGRAM, `OP_ERASE, `OP_SUSPEND,
								`OP_RESUME: is_status <= 1'b1;
								`OP_CLEAR_STATUS: is_status <= is_status;
								default:    is_status <= 1'b0;
							endcase
							if (cur_op == `OP_PROGRAM) prog_active <= 1'b1;
							if (cur_op == `OP_ERASE) begin
								erase_active <= 1'b1;
								need_clear   <= 1'b1;
							end
							if (cur_op == `OP_CLEAR_STATUS) begin
								need_clear  <= 1'b0;
								status_bits <= 8'h00;
							end
							if (cur_op == `OP_RESUME) begin
								if (program_suspended) begin
									program_suspended <= 1'b0;
									prog_active       <= 1'b1;
								end else if (erase_suspended) begin
									erase_suspended <= 1'b0;
									erase_active    <= 1'b1;
								end
							end
						end
					end
				end
				// Hold read strobes low
				S_RD: begin
					cnt <= cnt + 3'd1;
					if (cnt == `T_STROBE_CYC - 1) begin
						rd_data    <= flash_dq_in;
						flash_oe_n <= 1'b1;
						flash_ce_n <= 1'b1;
						cnt        <= 3'd0;
						state      <= S_RREC;
						if (is_status) begin
							status_bits <= flash_dq_in[7:0];
							if (flash_dq_in[`SB_READY]) begin
								if (prog_active && flash_dq_in[`SB_PROG_SUSP]) begin
									program_suspended <= 1'b1;
								end
								if (erase_active && !prog_active &&
								    flash_dq_in[`SB_ERASE_SUSP]) begin
									erase_suspended <= 1'b1;
								end
								prog_active  <= 1'b0;
								erase_active <= 1'b0;
							end
						end
					end
				end
				// Strobe recovery after read
				S_RREC: begin
					cnt <= cnt + 3'd1;
					if (cnt == `T_RECOVER_CYC - 1) begin
						cnt   <= 3'd0;
						state <= S_END;
					end
				end
				// Finish pulse
				S_END: begin
					op_done  <= ~op_rejected;
					op_ready <= 1'b1;
					state    <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Hold program word for second cycle
	always @(posedge mclk) begin
		if (sys_rst) begin
			op_data_hold <= {DW{1'b0}};
		end else if (state == S_IDLE && op_valid && op_ready) begin
			op_data_hold <= op_data;
		end
	end

endmodule // flash_cmd_host

/* hdl/flash_host_consts.vh */
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
// Command codes on the low data byte
`define CMD_READ_ARRAY     8'hff
`define CMD_READ_IDENT     8'h90
`define CMD_READ_QUERY     8'h98
`define CMD_READ_STATUS    8'h70
`define CMD_CLEAR_STATUS   8'h50
`define CMD_PROGRAM_SETUP  8'h40
`define CMD_PROGRAM_ALT    8'h10
`define CMD_ERASE_SETUP    8'h20
`define CMD_CONFIRM        8'hd0
`define CMD_SUSPEND        8'hb0
`define CMD_PROTECT_SETUP  8'h60
`define CMD_LOCK           8'h01
`define CMD_LOCK_DOWN      8'h2f
`define CMD_PROT_PROGRAM   8'hc0
// Status bit positions
`define SB_READY           7
`define SB_ERASE_SUSP      6
`define SB_ERASE_ERR       5
`define SB_PROG_ERR        4
`define SB_SUPPLY_ERR      3
`define SB_PROG_SUSP       2
`define SB_LOCK_ERR        1
// User operation codes
`define OP_READ_ARRAY      4'h0
`define OP_READ_IDENT      4'h1
`define OP_READ_QUERY      4'h2
`define OP_READ_STATUS     4'h3
`define OP_CLEAR_STATUS    4'h4
`define OP_PROGRAM         4'h5
`define OP_ERASE           4'h6
`define OP_SUSPEND         4'h7
`define OP_RESUME          4'h8
`define OP_LOCK            4'h9
`define OP_UNLOCK          4'ha
`define OP_LOCK_DOWN       4'hb
`define OP_PROT_PROGRAM    4'hc
`define OP_READ            4'hd
// Bus timing in ns and derived cycles at 25 MHz (40 ns)
`define CLK_PERIOD_NS      40
`define T_STROBE_NS        80
`define T_STROBE_CYC       ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RECOVER_NS       40
`define T_RECOVER_CYC      ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* testbench/flash_cmd_host_bench.sv */
`timescale 1ns/100ps
`include "flash_host_consts.vh"
// Self-checking bench for the host command sequencer
module flash_cmd_host_bench;
	localparam logic [15:0]	ID_W = 16'h5a3c;	// Arbitrary identifier
	localparam logic [15:0]	QRY_W = 16'h1e2d;	// Arbitrary query word
	logic		mclk = 0, sys_rst = 1, op_valid = 0, vpp_ok = 1, verify_ok = 1;
	logic [3:0]	op_code = 0;
	logic [22:0]	op_addr = 0, flash_addr;
	logic [15:0]	op_data = 0, rd_data, dq_out, dq_dev;
	logic [7:0]	status_bits;
	logic		op_ready, op_done, op_rejected, erase_susp, prog_susp, need_clear;
	logic		dq_oe, ce_n, oe_n, we_n;
	int		fail_count = 0, comparisons = 0, i;
	logic [7:0]	pcode [4] = '{8'h01, 8'hd0, 8'h2f, 8'haa};
	wire [15:0]	dq_bus = dq_oe ? dq_out : dq_dev;	// Shared data wire
	always #20 mclk = ~mclk;
	flash_cmd_host i_flash_cmd_host (.mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid),
		.op_code(op_code), .op_addr(op_addr), .op_data(op_data), .op_ready(op_ready),
		.op_done(op_done), .op_rejected(op_rejected), .rd_data(rd_data),
		.status_bits(status_bits), .erase_suspended(erase_susp),
		.program_suspended(prog_susp), .need_clear(need_clear), .flash_addr(flash_addr),
		.flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_bus),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .reset_power_down_n());
	flash_dev_model #(.BUSY(40), .ID_WORD(ID_W), .QRY_WORD(QRY_W)) i_flash_dev_model (
		.mclk(mclk), .addr(flash_addr), .dq_o(dq_bus), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .vpp_ok(vpp_ok), .verify_ok(verify_ok), .dq_i(dq_dev));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude;
		if (fail_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			fail_count++;
			conclude;
		end
	endtask
	// One request, then a bounded wait for its answer
	task automatic op(input logic [3:0] c, input logic [22:0] a, input logic [15:0] d,
			input logic rej);
		int n;
		n = 0;
		while (op_ready !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		op_valid = 1;
		op_code = c;
		op_addr = a;
		op_data = d;
		@(negedge mclk);
		op_valid = 0;
		while (op_done !== 1'b1 && op_rejected !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		bound(n, 300);
		chk("refusal", op_rejected, rej);
	endtask
	// Status command, then one read to capture the word
	task automatic rdst;
		op(`OP_READ_STATUS, 0, 0, 0);
		op(`OP_READ, 0, 0, 0);
	endtask
	task automatic poll;
		int n;
		n = 0;
		do begin
			rdst;
			n++;
		end while (status_bits[7] !== 1'b1 && n < 60);
		bound(n, 60);
	endtask
	task automatic rdw(input string nm, input logic [3:0] m, input logic [15:0] exp);
		op(m, 0, 0, 0);
		op(`OP_READ, 23'h10, 0, 0);
		chk(nm, rd_data, exp);
	endtask
	// Main sequence
	initial begin
		repeat (8) @(negedge mclk);
		sys_rst = 0;
		rdw("ident", `OP_READ_IDENT, ID_W);
		rdw("query", `OP_READ_QUERY, QRY_W);
		op(`OP_PROGRAM, 23'h10, 16'h12f4, 0);
		poll;
		rdw("program", `OP_READ_ARRAY, 16'h12f4);
		op(`OP_ERASE, 23'h8000, 0, 0);
		op(`OP_SUSPEND, 0, 0, 0);
		poll;
		chk("erase held", {status_bits[6], erase_susp}, 2'b11);
		op(`OP_CLEAR_STATUS, 0, 0, 1);
		op(`OP_PROGRAM, 23'h10, 16'h0034, 0);
		op(`OP_SUSPEND, 0, 0, 0);
		poll;
		chk("prog held", {status_bits[2], prog_susp}, 2'b11);
		op(`OP_ERASE, 23'h8000, 0, 1);
		rdw("other block", `OP_READ_ARRAY, 16'h12f4);
		op(`OP_RESUME, 0, 0, 0);
		rdst;
		chk("prog resumed", status_bits[7], 0);
		poll;
		chk("prog flags", {status_bits[2], prog_susp}, 0);
		op(`OP_RESUME, 0, 0, 0);
		rdst;
		chk("erase busy", status_bits[7], 0);
		poll;
		chk("erase ok", status_bits, 8'h80);
		rdw("erased", `OP_READ_ARRAY, 16'hffff);
		op(`OP_ERASE, 23'h8000, 0, 1);
		op(`OP_CLEAR_STATUS, 0, 0, 0);
		chk("cleared", {status_bits, need_clear}, 0);
		vpp_ok = 0;
		op(`OP_ERASE, 23'h8000, 0, 0);
		poll;
		chk("supply", status_bits, 8'ha8);
		rdst;
		chk("sticky", status_bits, 8'ha8);
		op(`OP_CLEAR_STATUS, 0, 0, 0);
		vpp_ok = 1;
		verify_ok = 0;
		op(`OP_ERASE, 23'h8000, 0, 0);
		poll;
		chk("verify", status_bits, 8'ha0);
		op(`OP_CLEAR_STATUS, 0, 0, 0);
		for (i = 0; i < 4; i++) begin
			op(4'h9 + i[3:0], 23'h8000, 16'h00aa, 0);
			chk("protect", i_flash_dev_model.last2, {8'h00, pcode[i]});
		end
		conclude;
	end
endmodule // flash_cmd_host_bench

/* testbench/flash_cmd_host_monitor.sv */
`timescale 1ns/100ps
`include "flash_host_consts.vh"
// Port-level watch on the host sequencer
module flash_cmd_host_monitor #(
	parameter AW = 23,
	parameter DW = 16
) (
	input wire logic		mclk,
	input wire logic		sys_rst,
	input wire logic		op_valid,
	input wire logic [3:0]		op_code,
	input wire logic [AW-1:0]	op_addr,
	input wire logic		op_ready,
	input wire logic		op_done,
	input wire logic		op_rejected,
	input wire logic [7:0]		status_bits,
	input wire logic		erase_suspended,
	input wire logic		program_suspended,
	input wire logic		need_clear,
	input wire logic [AW-1:0]	flash_addr,
	input wire logic [DW-1:0]	flash_dq_out,
	input wire logic		flash_dq_oe,
	input wire logic		flash_ce_n,
	input wire logic		flash_oe_n,
	input wire logic		flash_we_n
);
	logic [3:0]	last_op;	// Code of the last taken request
	logic [AW-1:0]	last_addr;	// Address of the last taken request
	wire		take = op_valid && op_ready;
	// Remember what was taken
	always @(posedge mclk) begin
		if (take) begin
			last_op <= op_code;
			last_addr <= op_addr;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence s_wlow; (!flash_we_n && !flash_ce_n) [*2]; endsequence
	sequence s_confirm;
		##[1:6] (!flash_we_n && flash_dq_out == 16'h00d0 && flash_addr == last_addr);
	endsequence
	property p_we_width; $fell(flash_we_n) |-> s_wlow ##1 flash_we_n; endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe width");
	property p_erase_seq; (!flash_we_n && flash_dq_out == 16'h0020) |-> s_confirm; endproperty
	a_erase_seq: assert property (p_erase_seq) else $error("erase confirm missing");
	property p_read; $fell(flash_oe_n) |-> !flash_ce_n && !flash_dq_oe && flash_we_n; endproperty
	a_read: assert property (p_read) else $error("read strobe bad");
	property p_clear;
		op_done && last_op == `OP_CLEAR_STATUS |-> status_bits == 8'h00 && !need_clear;
	endproperty
	a_clear: assert property (p_clear) else $error("clear status kept bits");
	property p_nc_rej; take && need_clear && op_code == `OP_ERASE |-> ##1 op_rejected; endproperty
	a_nc_rej: assert property (p_nc_rej) else $error("erase before clear taken");
	property p_ps_rej;
		take && program_suspended && op_code == `OP_ERASE |-> ##1 op_rejected;
	endproperty
	a_ps_rej: assert property (p_ps_rej) else $error("erase in program suspend");
	property p_es_rej;
		take && erase_suspended && op_code == `OP_CLEAR_STATUS |-> ##1 op_rejected;
	endproperty
	a_es_rej: assert property (p_es_rej) else $error("clear in erase suspend");
	property p_keep;
		op_rejected |-> erase_suspended == $past(erase_suspended, 2)
			&& program_suspended == $past(program_suspended, 2);
	endproperty
	a_keep: assert property (p_keep) else $error("refusal lost suspend");
endmodule // flash_cmd_host_monitor

bind flash_cmd_host flash_cmd_host_monitor #(.AW(AW), .DW(DW)) i_flash_cmd_host_monitor (
	.mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
	.op_addr(op_addr), .op_ready(op_ready), .op_done(op_done), .op_rejected(op_rejected),
	.status_bits(status_bits), .erase_suspended(erase_suspended),
	.program_suspended(program_suspended), .need_clear(need_clear),
	.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
	.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

/* testbench/flash_dev_model.sv */
`timescale 1ns/100ps
// Behavioural flash device; identification values are arbitrary
module flash_dev_model #(
	parameter BUSY = 20,
	parameter ID_WORD = 16'h5a3c,
	parameter QRY_WORD = 16'h1e2d
) (
	input wire logic	mclk,
	input wire logic [22:0]	addr,
	input wire logic [15:0]	dq_o,
	input wire logic	ce_n,
	input wire logic	oe_n,
	input wire logic	we_n,
	input wire logic	vpp_ok,
	input wire logic	verify_ok,
	output logic [15:0]	dq_i
);
	logic [7:0]	sr = 8'h80;	// Status bits
	logic [7:0]	pend = 8'h00;	// First write of a pair
	logic [7:0]	p;
	logic [1:0]	mode = 2'd0;	// Array, status, ident, query
	logic [15:0]	mem = 16'hffff, pdat, rd = 16'h0000, last2;
	logic [22:0]	eaddr;		// Latched erase block
	logic		psusp = 0, esusp = 0, preq = 0, ereq = 0;
	int		pcnt = 0, ecnt = 0;
	// Decode each write once its data settles
	always @(negedge we_n) begin
		#1;
		p = pend;
		pend = 8'h00;
		if (!ce_n) case (p)
			8'h40, 8'h10: begin
				pcnt = BUSY;
				pdat = dq_o;
				mode = 2'd1;
			end
			8'h20: begin
				eaddr = addr;
				mode = 2'd1;
				if (vpp_ok) ecnt = BUSY;
				else sr = sr | 8'h28;
			end
			8'h60, 8'hc0: last2 = dq_o;
			default: case (dq_o[7:0])
				8'hff: mode = 2'd0;
				8'h90: mode = 2'd2;
				8'h98: mode = 2'd3;
				8'h70: mode = 2'd1;
				8'h50: sr = sr & 8'hc4;
				8'hb0: begin
					preq = pcnt != 0 && !psusp;
					ereq = !preq && ecnt != 0 && !esusp;
					mode = 2'd1;
				end
				8'hd0: begin
					mode = 2'd1;
					sr[7] = 0;
					if (psusp) begin
						psusp = 0;
						sr[2] = 0;
					end else if (!ce_n) begin
						esusp = 0;
						sr[6] = 0;
					end
				end
				8'h40, 8'h10, 8'h20, 8'h60, 8'hc0: pend = dq_o[7:0];
				default: ;
			endcase
		endcase
	end
	always @(posedge mclk) begin
		if (preq) begin
			psusp = 1;
			preq = 0;
			sr[2] = 1;
		end else if (ereq) begin
			esusp = 1;
			ereq = 0;
			sr[6] = 1;
		end else if (pcnt != 0 && !psusp) begin
			pcnt = pcnt - 1;
			if (pcnt == 0) mem = mem & pdat;
		end else if (ecnt != 0 && !esusp) begin
			ecnt = ecnt - 1;
			if (ecnt == 0 && verify_ok) mem = 16'hffff;
			if (ecnt == 0 && !verify_ok) sr[5] = 1;
		end
		sr[7] = !(pcnt != 0 && !psusp || ecnt != 0 && !esusp);
	end
	// word frozen at the later strobe
	always @(negedge ce_n or negedge oe_n) begin
		#1;
		if (!ce_n && !oe_n) rd = mode == 2'd0 ? mem : mode == 2'd1 ? {8'h00, sr} :
			mode == 2'd2 ? ID_WORD : QRY_WORD;
	end
	// Released bus shows the inverse word
	assign dq_i = (!ce_n && !oe_n) ? rd : ~rd;
endmodule // flash_dev_model
